/* File: pkg/bus_arb_pkg.sv */
// types shared by the bus master arbitration block and its reload queue
package bus_arb_pkg;
`include "bus_arb_regs.svh"

  // address tenure state
  typedef enum logic [1:0] {
    A_IDLE = 2'b00,
    A_OWN = 2'b01,
    A_GAP = 2'b10
  } addr_st_e;

  // data tenure state
  typedef enum logic {
    D_IDLE = 1'b0,
    D_OWN = 1'b1
  } data_st_e;

  // snoop copyback queue state
  typedef enum logic [1:0] {
    CB_IDLE = 2'b00,
    CB_ADDR = 2'b01,
    CB_DATA = 2'b10
  } cb_st_e;

  // one outstanding reload request
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic icache;
  } reload_ent_s;

  // complete state of the arbitration block
  typedef struct packed {
    addr_st_e a_st;
    logic a_is_cb;
    logic [`ADDR_W-1:0] addr;
    logic addr_wr;
    data_st_e d_st;
    logic d_is_cb;
    logic [`BEAT_W-1:0] beat;
    cb_st_e cb_st;
    logic [`ADDR_W-1:0] cb_addr;
    logic [`CNT_W-1:0] cb_ahead;
    logic [`CNT_W-1:0] iss;
    logic ic_busy;
    logic l2h_valid;
    logic [`ADDR_W-1:0] l2h_addr;
    logic l2h_rel;
    logic [`DATA_W-1:0] rd_data;
    logic dc_we;
    logic l2_we;
    logic crit;
    logic wr_beat;
  } arb_state_s;

endpackage : bus_arb_pkg

/* File: pkg/bus_arb_regs.svh */
// constants for the bus master arbitration and miss pipelining block
`ifndef BUS_ARB_REGS_SVH
`define BUS_ARB_REGS_SVH

// bus widths
`define ADDR_W 32
`define DATA_W 64

// beats in a burst data tenure, last beat index
`define BEAT_W 2
`define BEAT_FIRST 2'h0
`define BEAT_LAST 2'h3

// reload queue geometry and count width
`define RLQ_DEPTH 4
`define CNT_W 3
`define CNT_ZERO 3'h0

// outstanding reload limits
`define MAX_RELOADS 3'h4
`define SQ_FULL_LIMIT 3'h2
`define NO_PIPE_LIMIT 3'h1

`endif

/* File: rtl/bus_master_arbiter.sv */
// bus master arbitration and pipelined miss tracking for the processor bus
`timescale 1ns/1ps
`include "bus_arb_regs.svh"

// Function
// - busy lines drive only while mastering the bus, else sampled as inputs
// - request the address bus whenever an address tenure is wanted
// - address grant qualified only with address busy and retry both negated
// - a parked grant is taken without first raising the request
// - address busy stays asserted for the whole address mastership
// - data grant qualified only with data busy, data retry, address retry negated
// - address retry disqualifies data only for its own address tenure
// - write-only grant takes the data bus for the pending write first
// - write-only grant with data grant and no write pending serves the read
// - a needed data bus with qualified grant is always taken, busy asserted
// - pipelined miss mode allows four reloads back to back, tracked here
// - first level cache keeps hitting, stalls a second miss without pipelining
// - level two hit data is held until allocation needs it
// - level two misses reach the bus unit through three extra queue slots
// - reload beats go to both reload buffers, critical word forwarded
// - snoop copybacks use their own queue, fifth tenure, enveloped writes
// - at most four reloads, only one of them from the instruction cache
// - double misses leave as pipelined address tenures
// - a full store queue throttles pipelined misses
// - reloads held in a four deep queue independent of load/store queues
// - data cache forwards misses and keeps no tracking state
// - address busy negated at least one clock after address acknowledge
// - all bus inputs sampled and outputs driven on the rising clock edge
module bus_master_arbiter (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // mode and throttle
  input wire logic pipelined_miss_mode_i,
  input wire logic store_queue_full_i,
  // miss requests from the caches
  input wire logic miss_valid_i,
  input wire logic [`ADDR_W-1:0] miss_addr_i,
  input wire logic miss_icache_i,
  input wire logic miss_l2_hit_i,
  output logic miss_ready_o,
  // level two hit hold
  input wire logic alloc_need_i,
  output logic l2_hit_release_o,
  output logic [`ADDR_W-1:0] l2_hit_addr_o,
  // snoop copyback queue
  input wire logic cb_valid_i,
  input wire logic [`ADDR_W-1:0] cb_addr_i,
  output logic cb_ready_o,
  output logic cb_beat_done_o,
  // address bus arbitration and transfer
  output logic addr_bus_request_o,
  input wire logic addr_bus_grant_i,
  input wire logic addr_bus_busy_i,
  output logic addr_bus_busy_o,
  output logic addr_bus_busy_oe_n_o,
  input wire logic addr_retry_i,
  input wire logic addr_acknowledge_i,
  output logic [`ADDR_W-1:0] addr_o,
  output logic addr_write_o,
  // data bus arbitration and transfer
  input wire logic data_bus_grant_i,
  input wire logic write_only_data_grant_i,
  input wire logic data_bus_busy_i,
  output logic data_bus_busy_o,
  output logic data_bus_busy_oe_n_o,
  input wire logic data_retry_i,
  input wire logic data_beat_ack_i,
  input wire logic [`DATA_W-1:0] data_i,
  // reload data to the cache buffers
  output logic [`DATA_W-1:0] reload_data_o,
  output logic reload_dc_we_o,
  output logic reload_l2_we_o,
  output logic crit_word_valid_o
);

  bus_arb_pkg::arb_state_s s_r;
  bus_arb_pkg::arb_state_s s_nxt;

  logic [`CNT_W-1:0] q_cnt, reload_limit, cb_ahead_now;
  bus_arb_pkg::reload_ent_s q_rd_ent, q_head, push_ent;
  logic q_full, miss_push, l2h_take, want_cb, want_rd, need_addr, qual_ag;
  logic a_done, rd_acked, rd_avail, cb_avail, cb_first, pick_cb, pick_rd;
  logic rel_addr_retry, qual_dg, d_start, beat_ok, last_beat, q_pop;

  // the reload queue: one normal slot plus three extra level two to bus slots
  reload_queue #(
    .DEPTH(`RLQ_DEPTH),
    .CW(`CNT_W)
  ) u_rlq (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .push_i(miss_push),
    .push_ent_i(push_ent),
    .pop_i(q_pop),
    .rd_idx_i(s_r.iss),
    .rd_ent_o(q_rd_ent),
    .head_ent_o(q_head),
    .count_o(q_cnt),
    .full_o(q_full)
  );

  assign push_ent = '{addr: miss_addr_i, icache: miss_icache_i};

  // outstanding limit: one without pipelining, two with a full store queue
  assign reload_limit = !pipelined_miss_mode_i ? `NO_PIPE_LIMIT :
                        (store_queue_full_i ? `SQ_FULL_LIMIT : `MAX_RELOADS);

  // miss intake; the cache side only hands over, all tracking lives here
  assign miss_ready_o = miss_l2_hit_i ? !s_r.l2h_valid :
                        ((q_cnt < reload_limit) && !q_full &&
                         !(miss_icache_i && s_r.ic_busy));
  assign miss_push = miss_valid_i && miss_ready_o && !miss_l2_hit_i;
  assign l2h_take = miss_valid_i && miss_ready_o && miss_l2_hit_i;

  // address side: copyback goes first, ahead of every reload address not yet issued
  assign want_cb = (s_r.cb_st == bus_arb_pkg::CB_ADDR);
  assign want_rd = (s_r.iss < q_cnt);
  assign need_addr = want_cb || want_rd;
  assign qual_ag = addr_bus_grant_i && !addr_bus_busy_i && !addr_retry_i;
  assign addr_bus_request_o = need_addr && (s_r.a_st != bus_arb_pkg::A_OWN);
  assign a_done = (s_r.a_st == bus_arb_pkg::A_OWN) && addr_acknowledge_i;
  assign rd_acked = a_done && !addr_retry_i && !s_r.a_is_cb;

  // data candidates; a tenure may start in the cycle its address is acknowledged
  assign rd_avail = (s_r.iss != `CNT_ZERO) || (a_done && !s_r.a_is_cb);
  assign cb_avail = (s_r.cb_st == bus_arb_pkg::CB_DATA) || (a_done && s_r.a_is_cb);
  assign cb_ahead_now = (s_r.cb_st == bus_arb_pkg::CB_DATA) ? s_r.cb_ahead : s_r.iss;
  assign cb_first = cb_avail && (cb_ahead_now == `CNT_ZERO);
  assign pick_cb = cb_avail && (write_only_data_grant_i || cb_first);
  assign pick_rd = !pick_cb && rd_avail;

  // address retry only counts against the tenure whose address it terminates
  assign rel_addr_retry = addr_retry_i && a_done &&
                     (pick_cb ? s_r.a_is_cb : (!s_r.a_is_cb && (s_r.iss == `CNT_ZERO)));
  assign qual_dg = data_bus_grant_i && !data_bus_busy_i && !data_retry_i && !rel_addr_retry;
  assign d_start = (s_r.d_st == bus_arb_pkg::D_IDLE) && (pick_cb || pick_rd) && qual_dg;

  // beat accounting; a data retry beat is not counted
  assign beat_ok = (s_r.d_st == bus_arb_pkg::D_OWN) && data_beat_ack_i && !data_retry_i;
  assign last_beat = beat_ok && (s_r.beat == `BEAT_LAST);
  assign q_pop = last_beat && !s_r.d_is_cb;

  // next state of the whole block
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.l2h_rel = 1'b0;
    s_nxt.dc_we = 1'b0;
    s_nxt.l2_we = 1'b0;
    s_nxt.crit = 1'b0;
    s_nxt.wr_beat = 1'b0;

    // address tenure; parked grant needs no request, idle-only entry gives the gap
    unique case (s_r.a_st)
      bus_arb_pkg::A_IDLE:
      begin
        if (need_addr && qual_ag)
        begin
          s_nxt.a_st = bus_arb_pkg::A_OWN;
          s_nxt.a_is_cb = want_cb;
          s_nxt.addr = want_cb ? s_r.cb_addr : q_rd_ent.addr;
          s_nxt.addr_wr = want_cb;
        end
      end
      bus_arb_pkg::A_OWN:
      begin
        if (addr_acknowledge_i)
        begin
          s_nxt.a_st = bus_arb_pkg::A_GAP;
          if (!addr_retry_i && s_r.a_is_cb)
          begin
            s_nxt.cb_st = bus_arb_pkg::CB_DATA;
            s_nxt.cb_ahead = s_r.iss - {{(`CNT_W-1){1'b0}}, q_pop};
          end
        end
      end
      bus_arb_pkg::A_GAP:
      begin
        s_nxt.a_st = bus_arb_pkg::A_IDLE;
      end
      default:
      begin
        s_nxt.a_st = bus_arb_pkg::A_IDLE;
      end
    endcase

    // issued count is relative to the queue head
    s_nxt.iss = s_r.iss + {{(`CNT_W-1){1'b0}}, rd_acked} -
                {{(`CNT_W-1){1'b0}}, q_pop};

    // reads completing ahead of a waiting copyback move it forward
    if ((s_r.cb_st == bus_arb_pkg::CB_DATA) && q_pop && (s_r.cb_ahead != `CNT_ZERO))
      s_nxt.cb_ahead = s_r.cb_ahead - 1'b1;

    // copyback intake into its dedicated single slot
    if (cb_valid_i && (s_r.cb_st == bus_arb_pkg::CB_IDLE))
    begin
      s_nxt.cb_st = bus_arb_pkg::CB_ADDR;
      s_nxt.cb_addr = cb_addr_i;
    end

    // data tenure
    unique case (s_r.d_st)
      bus_arb_pkg::D_IDLE:
      begin
        if (d_start)
        begin
          s_nxt.d_st = bus_arb_pkg::D_OWN;
          s_nxt.d_is_cb = pick_cb;
          s_nxt.beat = `BEAT_FIRST;
        end
      end
      bus_arb_pkg::D_OWN:
      begin
        if (beat_ok)
        begin
          s_nxt.beat = s_r.beat + 1'b1;
          if (s_r.d_is_cb)
          begin
            s_nxt.wr_beat = 1'b1;
          end
          else
          begin
            s_nxt.rd_data = data_i;
            s_nxt.dc_we = 1'b1;
            s_nxt.l2_we = 1'b1;
            s_nxt.crit = (s_r.beat == `BEAT_FIRST);
          end
        end
        if (last_beat)
        begin
          s_nxt.d_st = bus_arb_pkg::D_IDLE;
          if (s_r.d_is_cb)
            s_nxt.cb_st = bus_arb_pkg::CB_IDLE;
        end
      end
    endcase

    // instruction cache may own a single reload; a new push wins over the clear
    if (q_pop && q_head.icache)
      s_nxt.ic_busy = 1'b0;
    if (miss_push && miss_icache_i)
      s_nxt.ic_busy = 1'b1;

    // level two hit data parked until the data cache allocates
    if (s_r.l2h_valid && alloc_need_i)
    begin
      s_nxt.l2h_valid = 1'b0;
      s_nxt.l2h_rel = 1'b1;
    end
    if (l2h_take)
    begin
      s_nxt.l2h_valid = 1'b1;
      s_nxt.l2h_addr = miss_addr_i;
    end
  end

  // single state register; every bus pin changes only on this edge
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // busy pins driven only while master, released to the pull-up otherwise
  assign addr_bus_busy_o = (s_r.a_st == bus_arb_pkg::A_OWN);
  assign addr_bus_busy_oe_n_o = !addr_bus_busy_o;
  assign data_bus_busy_o = (s_r.d_st == bus_arb_pkg::D_OWN);
  assign data_bus_busy_oe_n_o = !data_bus_busy_o;

  // registered data outputs
  assign addr_o = s_r.addr;
  assign addr_write_o = s_r.addr_wr;
  assign cb_ready_o = (s_r.cb_st == bus_arb_pkg::CB_IDLE);
  assign cb_beat_done_o = s_r.wr_beat;
  assign reload_data_o = s_r.rd_data;
  assign reload_dc_we_o = s_r.dc_we;
  assign reload_l2_we_o = s_r.l2_we;
  assign crit_word_valid_o = s_r.crit;
  assign l2_hit_release_o = s_r.l2h_rel;
  assign l2_hit_addr_o = s_r.l2h_addr;

  // address mastership only follows a qualified grant
  property p_addr_qual;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(addr_bus_busy_o) |-> $past(addr_bus_grant_i && !addr_bus_busy_i && !addr_retry_i);
  endproperty
  a_addr_qual: assert property (p_addr_qual)
    else $error("address bus taken without qualified grant");

  // busy held until acknowledge
  property p_abb_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    addr_bus_busy_o && !addr_acknowledge_i |=> addr_bus_busy_o;
  endproperty
  a_abb_hold: assert property (p_abb_hold)
    else $error("address busy dropped before acknowledge");

  // at least two idle clocks after acknowledge
  property p_abb_gap;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    addr_bus_busy_o && addr_acknowledge_i |=> !addr_bus_busy_o ##1 !addr_bus_busy_o;
  endproperty
  a_abb_gap: assert property (p_abb_gap)
    else $error("address busy not negated after acknowledge");

  // output enables follow mastership on both busy pins
  property p_oe_pins;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_bus_busy_oe_n_o != addr_bus_busy_o) && (data_bus_busy_oe_n_o != data_bus_busy_o);
  endproperty
  a_oe_pins: assert property (p_oe_pins)
    else $error("busy pin enable disagrees with mastership");

  // request raised whenever an address is wanted and not owned
  property p_req;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    need_addr && !addr_bus_busy_o |-> addr_bus_request_o;
  endproperty
  a_req: assert property (p_req)
    else $error("address wanted but no bus request");

  // data mastership only follows a qualified data grant
  property p_data_qual;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(data_bus_busy_o) |-> $past(data_bus_grant_i && !data_bus_busy_i && !data_retry_i);
  endproperty
  a_data_qual: assert property (p_data_qual)
    else $error("data bus taken without qualified grant");

  // reload count never exceeds the maximum of four
  property p_max_reloads;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    q_cnt <= `MAX_RELOADS;
  endproperty
  a_max_reloads: assert property (p_max_reloads)
    else $error("more than four reloads outstanding");

  // full store queue caps new bus misses at two
  property p_sq_throttle;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    pipelined_miss_mode_i && store_queue_full_i && miss_push |=> q_cnt <= `SQ_FULL_LIMIT;
  endproperty
  a_sq_throttle: assert property (p_sq_throttle)
    else $error("pipelined miss accepted past store queue throttle");

  // level two hit released only on allocation demand
  property p_l2_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    l2_hit_release_o |-> $past(alloc_need_i && s_r.l2h_valid);
  endproperty
  a_l2_hold: assert property (p_l2_hold)
    else $error("level two hit data released without allocation");

  // every read beat lands in both reload buffers
  property p_both_buffers;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    reload_dc_we_o |-> reload_l2_we_o && !cb_beat_done_o;
  endproperty
  a_both_buffers: assert property (p_both_buffers)
    else $error("reload beat missed a buffer");

endmodule : bus_master_arbiter

/* File: rtl/reload_queue.sv */
// in-order queue of outstanding reload requests with an indexed read port
`timescale 1ns/1ps
`include "bus_arb_regs.svh"

module reload_queue #(
  parameter int DEPTH = `RLQ_DEPTH,
  parameter int CW = `CNT_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic push_i,
  input wire bus_arb_pkg::reload_ent_s push_ent_i,
  // drain side
  input wire logic pop_i,
  input wire logic [CW-1:0] rd_idx_i,
  output bus_arb_pkg::reload_ent_s rd_ent_o,
  output bus_arb_pkg::reload_ent_s head_ent_o,
  output logic [CW-1:0] count_o,
  output logic full_o
);

  typedef struct packed {
    bus_arb_pkg::reload_ent_s [DEPTH-1:0] mem;
    logic [CW-1:0] cnt;
  } rlq_state_s;

  rlq_state_s q_r;
  rlq_state_s q_nxt;
  logic [CW-1:0] base;

  // shift queue: the head always sits in slot zero, so order is free
  always_comb
  begin
    q_nxt = q_r;
    base = q_r.cnt;
    if (pop_i && (q_r.cnt != '0))
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        q_nxt.mem[i] = q_r.mem[i+1];
      end
      base = q_r.cnt - 1'b1;
    end
    if (push_i && (base != CW'(DEPTH)))
    begin
      q_nxt.mem[base] = push_ent_i;
      q_nxt.cnt = base + 1'b1;
    end
    else
    begin
      q_nxt.cnt = base;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  // caller uses rd_ent_o only while rd_idx_i is below count; slot contents beyond it are stale
  assign rd_ent_o = q_r.mem[rd_idx_i];
  assign head_ent_o = q_r.mem[0];
  assign count_o = q_r.cnt;
  assign full_o = (q_r.cnt == CW'(DEPTH));

endmodule : reload_queue

/* File: testbench/bus_master_arbitration_miss_pipelining_tb.sv */
// self-checking bench for the bus master arbitration block
`timescale 1ns/1ps
`include "bus_arb_regs.svh"

module bus_master_arbitration_miss_pipelining_tb;
  logic sys_clk_i, resetn_i, pipelined_miss_mode_i, store_queue_full_i, miss_valid_i;
  logic miss_icache_i, miss_l2_hit_i, alloc_need_i, cb_valid_i, miss_ready_o;
  logic [`ADDR_W-1:0] miss_addr_i, cb_addr_i, addr_o, l2_hit_addr_o, last_a;
  logic parked, hold, wo_en, rt_once, dr_once, slow, other_abb;
  logic addr_bus_busy_i, data_bus_busy_i, l2_hit_release_o, cb_ready_o, cb_beat_done_o;
  logic addr_bus_request_o, addr_bus_busy_o, addr_bus_busy_oe_n_o, addr_write_o;
  logic data_bus_busy_o, data_bus_busy_oe_n_o, addr_bus_grant_i, addr_retry_i;
  logic addr_acknowledge_i, data_bus_grant_i, write_only_data_grant_i, data_retry_i;
  logic data_beat_ack_i, reload_dc_we_o, reload_l2_we_o, crit_word_valid_o;
  logic [`DATA_W-1:0] data_i, reload_data_o, e_m;
  logic [`DATA_W-1:0] exp_q[$];
  logic busy_q, req_q, other_q, ack_q;
  logic [31:0] rnd;
  int n_fail = 0, checks = 0, n_cb = 0, n_rel = 0, rel_at_cb = 99;

  // busy lines resolved from every driver, negated when nobody drives
  assign addr_bus_busy_i = (!addr_bus_busy_oe_n_o & addr_bus_busy_o) | other_abb;
  assign data_bus_busy_i = !data_bus_busy_oe_n_o & data_bus_busy_o;

  bus_master_arbiter dut (.sys_clk_i, .resetn_i, .pipelined_miss_mode_i, .store_queue_full_i,
    .miss_valid_i, .miss_addr_i, .miss_icache_i, .miss_l2_hit_i, .miss_ready_o, .alloc_need_i,
    .l2_hit_release_o, .l2_hit_addr_o, .cb_valid_i, .cb_addr_i, .cb_ready_o, .cb_beat_done_o,
    .addr_bus_request_o, .addr_bus_grant_i, .addr_bus_busy_i, .addr_bus_busy_o,
    .addr_bus_busy_oe_n_o, .addr_retry_i, .addr_acknowledge_i, .addr_o, .addr_write_o,
    .data_bus_grant_i, .write_only_data_grant_i, .data_bus_busy_i, .data_bus_busy_o,
    .data_bus_busy_oe_n_o, .data_retry_i, .data_beat_ack_i, .data_i, .reload_data_o,
    .reload_dc_we_o, .reload_l2_we_o, .crit_word_valid_o);

  bus_partner far (.sys_clk_i, .resetn_i, .parked_i(parked), .hold_data_i(hold),
    .wo_en_i(wo_en), .retry_once_i(rt_once), .data_retry_once_i(dr_once), .slow_i(slow),
    .addr_bus_request_i(addr_bus_request_o), .addr_busy_i(addr_bus_busy_o), .addr_i(addr_o),
    .addr_write_i(addr_write_o), .data_busy_i(data_bus_busy_o),
    .addr_bus_grant_o(addr_bus_grant_i), .addr_retry_o(addr_retry_i),
    .addr_acknowledge_o(addr_acknowledge_i), .data_bus_grant_o(data_bus_grant_i),
    .write_only_data_grant_o(write_only_data_grant_i), .data_retry_o(data_retry_i),
    .data_beat_ack_o(data_beat_ack_i), .data_o(data_i));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // offer one line-aligned miss at a falling edge; reads queue four beats
  task automatic miss(input logic l2, input logic ic, input logic ex);
    logic took;
    took = 1'b0;
    rnd = lfsr(rnd);
    last_a = {rnd[31:5], 5'h0};
    miss_valid_i = 1'b1;
    miss_addr_i = last_a;
    miss_l2_hit_i = l2;
    miss_icache_i = ic;
    for (int t = 0; t < 8 && !took; t++)
    begin
      #1;
      took = (miss_ready_o === 1'b1);
      @(negedge sys_clk_i);
    end
    miss_valid_i = 1'b0;
    @(negedge sys_clk_i);
    if (took && !l2)
      for (int b = 0; b < 4; b++)
        exp_q.push_back({last_a, 30'h0, b[1:0]});
    chk("miss taken", ex, took);
  endtask : miss

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || data_bus_busy_o !== 1'b0 || cb_ready_o !== 1'b1) && n < 500)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 500) chk("drain", 0, 1);
    repeat (4) @(negedge sys_clk_i);
  endtask : drain

  // scoreboard and bus watcher, reading values from before this edge
  always @(posedge sys_clk_i)
  begin
    if (resetn_i === 1'b1)
    begin
      if (reload_dc_we_o === 1'b1)
      begin
        if (exp_q.size() == 0) chk("reload_dc_we_o", 0, 1);
        else
        begin
          e_m = exp_q.pop_front();
          chk("reload_data_o", e_m, reload_data_o);
          chk("reload_l2_we_o", 1, reload_l2_we_o);
          chk("crit_word_valid_o", e_m[1:0] == 2'h0, crit_word_valid_o);
          n_rel++;
        end
      end
      if (cb_beat_done_o === 1'b1)
      begin
        if (n_cb == 0) rel_at_cb = n_rel;
        n_cb++;
      end
      chk("addr busy enable", 1, addr_bus_busy_o ^ addr_bus_busy_oe_n_o);
      chk("data busy enable", 1, data_bus_busy_o ^ data_bus_busy_oe_n_o);
      if (ack_q) chk("addr_bus_busy_o after ack", 0, addr_bus_busy_o);
      if (addr_bus_busy_o === 1'b1 && busy_q === 1'b0)
      begin
        if (!parked) chk("addr_bus_request_o", 1, req_q);
        chk("foreign busy at grant", 0, other_q);
      end
    end
    busy_q <= addr_bus_busy_o;
    req_q <= addr_bus_request_o;
    other_q <= other_abb;
    ack_q <= addr_acknowledge_i & addr_bus_busy_o & !addr_retry_i;
  end

  initial
  begin
    #1000000;
    chk("watchdog", 0, 1);
    end_of_test();
  end

  initial
  begin
    {resetn_i, pipelined_miss_mode_i, store_queue_full_i, miss_valid_i, miss_icache_i} = 5'h0;
    {miss_l2_hit_i, alloc_need_i, cb_valid_i, parked, hold, wo_en, rt_once, dr_once} = 8'h0;
    {slow, other_abb, busy_q, req_q, other_q, ack_q} = 6'h0;
    {miss_addr_i, cb_addr_i} = 64'h0;
    rnd = 32'h5582;
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    chk("addr_bus_busy_o", 0, addr_bus_busy_o);
    chk("cb_ready_o", 1, cb_ready_o);
    // lone read, write-only grant with no write pending
    pipelined_miss_mode_i = 1'b1;
    wo_en = 1'b1;
    miss(0, 0, 1);
    drain();
    // four in flight, one icache at most, fifth refused
    hold = 1'b1;
    miss(0, 1, 1);
    miss(0, 1, 0);
    miss(0, 0, 1);
    miss(0, 0, 1);
    miss(0, 0, 1);
    miss(0, 0, 0);
    hold = 1'b0;
    drain();
    // no pipelining: a second miss stalls
    pipelined_miss_mode_i = 1'b0;
    hold = 1'b1;
    miss(0, 0, 1);
    miss(0, 0, 0);
    hold = 1'b0;
    drain();
    // full store queue lowers the limit to two
    pipelined_miss_mode_i = 1'b1;
    store_queue_full_i = 1'b1;
    hold = 1'b1;
    miss(0, 0, 1);
    miss(0, 0, 1);
    miss(0, 0, 0);
    {hold, store_queue_full_i} = 2'h0;
    drain();
    // level two hit waits for allocation
    miss(1, 0, 1);
    repeat (3) @(negedge sys_clk_i) chk("l2_hit_release_o", 0, l2_hit_release_o);
    alloc_need_i = 1'b1;
    @(negedge sys_clk_i);
    alloc_need_i = 1'b0;
    chk("l2_hit_release_o", 1, l2_hit_release_o);
    chk("l2_hit_addr_o", last_a, l2_hit_addr_o);
    // slow acknowledge with a retried address and a retried beat
    {slow, rt_once, dr_once} = 3'h7;
    @(negedge sys_clk_i);
    {rt_once, dr_once} = 2'h0;
    miss(0, 0, 1);
    drain();
    slow = 1'b0;
    // parked grant while another master holds the address bus
    {parked, other_abb} = 2'h3;
    miss(0, 0, 1);
    repeat (6) @(negedge sys_clk_i) chk("addr_bus_busy_o", 0, addr_bus_busy_o);
    other_abb = 1'b0;
    miss(0, 0, 1);
    drain();
    parked = 1'b0;
    // copyback behind an earlier read: overtakes only under the write-only grant
    for (int w = 1; w >= 0; w--)
    begin
      wo_en = w[0];
      hold = 1'b1;
      n_rel = 0;
      n_cb = 0;
      miss(0, 0, 1);
      repeat (10) @(negedge sys_clk_i);
      cb_valid_i = 1'b1;
      cb_addr_i = {rnd[26:0], 5'h0};
      @(negedge sys_clk_i);
      cb_valid_i = 1'b0;
      repeat (20) @(negedge sys_clk_i);
      hold = 1'b0;
      drain();
      chk("cb_beat_done_o count", 4, n_cb);
      chk("reloads before copyback", w ? 0 : 4, rel_at_cb);
    end
    end_of_test();
  end
endmodule : bus_master_arbitration_miss_pipelining_tb

/* File: testbench/bus_partner.sv */
// far-side model: central bus arbiter plus memory controller, in order except a pending write served first under write-only grant
`timescale 1ns/1ps
`include "bus_arb_regs.svh"

module bus_partner (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // bench controls
  input wire logic parked_i,
  input wire logic hold_data_i,
  input wire logic wo_en_i,
  input wire logic retry_once_i,
  input wire logic data_retry_once_i,
  input wire logic slow_i,
  // watched master outputs
  input wire logic addr_bus_request_i,
  input wire logic addr_busy_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic addr_write_i,
  input wire logic data_busy_i,
  // answers to the master
  output logic addr_bus_grant_o,
  output logic addr_retry_o,
  output logic addr_acknowledge_o,
  output logic data_bus_grant_o,
  output logic write_only_data_grant_o,
  output logic data_retry_o,
  output logic data_beat_ack_o,
  output logic [`DATA_W-1:0] data_o
);
  logic [`ADDR_W:0] pend[$];
  logic serving, cool, rt_pend, dr_pend;
  int wait_n, beat, idx;

  initial {addr_bus_grant_o, addr_retry_o, addr_acknowledge_o, data_bus_grant_o} = 4'h0;
  initial {write_only_data_grant_o, data_retry_o, data_beat_ack_o, data_o} = 67'h0;

  // one clocked process for the whole far side, so update order is fixed
  always @(posedge sys_clk_i)
  begin
    addr_acknowledge_o <= 1'b0;
    addr_retry_o <= 1'b0;
    data_beat_ack_o <= 1'b0;
    data_retry_o <= 1'b0;
    data_bus_grant_o <= 1'b0;
    write_only_data_grant_o <= 1'b0;
    if (!resetn_i)
    begin
      pend.delete();
      {serving, cool, rt_pend, dr_pend} = 4'h0;
      wait_n = 0;
      addr_bus_grant_o <= 1'b0;
    end
    else
    begin
      if (retry_once_i) rt_pend = 1'b1;
      if (data_retry_once_i) dr_pend = 1'b1;
      // grant follows the request a clock late, or stands while parked
      addr_bus_grant_o <= parked_i | addr_bus_request_i;
      // retry only ever rides on the acknowledge of its own tenure
      if (addr_busy_i && !addr_acknowledge_o)
      begin
        wait_n++;
        if (wait_n > (slow_i ? 3 : 0))
        begin
          addr_acknowledge_o <= 1'b1;
          addr_retry_o <= rt_pend;
          if (!rt_pend) pend.push_back({addr_write_i, addr_i});
          rt_pend = 1'b0;
          wait_n = 0;
        end
      end
      // data served from the queue, the address need not stay on the bus
      if (!data_busy_i) cool = 1'b0;
      if (!serving && !cool && !data_busy_i && pend.size() > 0 && !hold_data_i)
      begin
        data_bus_grant_o <= 1'b1;
        write_only_data_grant_o <= wo_en_i;
      end
      if (data_busy_i && !serving && !cool)
      begin
        serving = 1'b1;
        beat = 0;
        idx = 0;
        if (write_only_data_grant_o)
          foreach (pend[i])
            if (pend[i][`ADDR_W] && idx == 0) idx = i;
      end
      if (serving)
      begin
        data_beat_ack_o <= 1'b1;
        data_o <= {pend[idx][`ADDR_W-1:0], 30'h0, beat[1:0]};
        if (dr_pend && beat == 1)
        begin
          data_retry_o <= 1'b1;
          dr_pend = 1'b0;
        end
        else beat++;
        if (beat == 4)
        begin
          pend.delete(idx);
          serving = 1'b0;
          cool = 1'b1;
        end
      end
      else data_o <= ~data_o; // released bus inverts every bit each clock instead of holding the last beat
    end
  end
endmodule : bus_partner
